//--- shared/tcs_consts.svh
// Offsets, field positions, reset values and widths of the timer channel status and compare block.
// Assumes byte offsets on a 16-bit register port; included by bare name.
`ifndef TCS_CONSTS_SVH
`define TCS_CONSTS_SVH

`define TCS_ADDR_W          16
`define TCS_DATA_W          16
`define TCS_OFF_FLAGS       16'hFFF5
`define TCS_OFF_GRA         16'hFFF8
`define TCS_OFF_GRB         16'hFFFA
`define TCS_OFF_CTRL        16'hFFF0
`define TCS_OFF_IRQ_STAT    16'hFFE0
`define TCS_OFF_IRQ_MASK    16'hFFE2
`define TCS_BIT_FLAG_A      0
`define TCS_BIT_FLAG_B      1
`define TCS_BIT_OVF         4
`define TCS_BIT_UNF         5
`define TCS_BIT_RSV6        6
`define TCS_BIT_DIR         7
`define TCS_FLAGS_RESERVED  8'h40
`define TCS_GR_RESET        16'hFFFF
`define TCS_CNT_MAX         16'hFFFF
`define TCS_CNT_ZERO        16'h0000
`define TCS_CTRL_RUN        0
`define TCS_CTRL_UPDN       1
`define TCS_CTRL_CAP_A      2
`define TCS_CTRL_CAP_B      3
`define TCS_CTRL_IEN_A      4
`define TCS_CTRL_IEN_B      5
`define TCS_CTRL_IEN_V      6
`define TCS_CTRL_IEN_U      7
`define TCS_IRQ_W           4

`endif

//--- shared/tcs_pkg.sv
// Types shared by the timer channel status and compare block.
// Assumes the constants header is compiled alongside.
package tcs_pkg;
    typedef enum logic [1:0] {
        TCS_CNT_HOLD,
        TCS_CNT_UP,
        TCS_CNT_DOWN
    } tcs_step_t;
endpackage

//--- hw/tcs_flag.sv
// One clearable event flag with read-then-write-zero clearing.
// Assumes the set, read and clear qualifiers are single-cycle pulses on clk_in.
`timescale 1ns/1ps
module tcs_flag (
    // Clock and reset.
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    // Hardware event and software or transfer controller access.
    input  wire logic set_in,
    input  wire logic read_in,
    input  wire logic write_zero_in,
    input  wire logic xfer_clear_in,
    // Flag state.
    output logic      flag_out
);
    logic armed;

    // Arm on a read that sees the flag set; a write of zero then consumes it.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            armed <= 1'b0;
        end else if (read_in && flag_out) begin
            armed <= 1'b1;
        end else if (write_zero_in || !flag_out) begin
            armed <= 1'b0;
        end
    end

    // Set beats any clear arriving in the same cycle.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            flag_out <= 1'b0;
        end else if (set_in) begin
            flag_out <= 1'b1;
        end else if ((write_zero_in && armed) || xfer_clear_in) begin
            flag_out <= 1'b0;
        end
    end
endmodule

//--- hw/tcs_gr.sv
// One 16-bit general register working as compare or capture register.
// Assumes capture strobe is synchronous and one cycle long.
`timescale 1ns/1ps
`include "tcs_consts.svh"
module tcs_gr (
    // Clock and reset.
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    // Mode, software write and counter.
    input  wire logic        cap_mode_in,
    input  wire logic        capture_in,
    input  wire logic        wr_in,
    input  wire logic [15:0] wdata_in,
    input  wire logic [15:0] count_in,
    input  wire logic        count_step_in,
    // Register value and event.
    output logic [15:0]      value_out,
    output logic             event_out
);
    // Capture copies the counter; a software write loads otherwise.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            value_out <= `TCS_GR_RESET;
        end else if (cap_mode_in && capture_in) begin
            value_out <= count_in;
        end else if (wr_in) begin
            value_out <= wdata_in;
        end
    end

    // Event marks a match in compare mode or a capture in capture mode.
    always_comb begin
        if (cap_mode_in) begin
            event_out = capture_in;
        end else begin
            event_out = count_step_in && (count_in == value_out);
        end
    end
endmodule

//--- hw/tcs_channel.sv
// Timer channel: counter, event flags, two general registers, register port and interrupt.
// Assumes a single-cycle strobe register port on clk_in and synchronous pulse inputs.
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
`include "tcs_consts.svh"

// How it works
// - Compare mode A: counter equal to register A sets flag A.
// - Capture mode A: capture copies counter into A and sets flag A.
// - Compare mode B: counter equal to register B sets flag B.
// - Capture mode B: capture copies counter into B and sets flag B.
// - A zero write clears a flag only after it was read as one.
// - Writing one to a flag leaves it unchanged.
// - Transfer controller clears its flag only with disable select low, count nonzero.
// - Counter wrap from all ones to zero sets the overflow flag.
// - Counting down from zero to all ones sets the underflow flag.
// - Up/down only with the up/down mode bit set; direction flag one when up.
// - Registers A and B are 16 bits and reset to all ones.
// - Compare flag interrupt requests are gated by their enable bits.
module tcs_channel
    import tcs_pkg::*;
(
    // Clock and reset.
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    // Register port.
    input  wire logic [15:0] addr_in,
    input  wire logic [15:0] wdata_in,
    input  wire logic        wr_in,
    input  wire logic        rd_in,
    output logic [15:0]      rdata_out,
    // Counting sources.
    input  wire logic        count_tick_in,
    input  wire logic        count_down_in,
    input  wire logic        capture_a_in,
    input  wire logic        capture_b_in,
    // Transfer controller clears.
    input  wire logic        xfer_act_a_in,
    input  wire logic        xfer_act_b_in,
    input  wire logic        transfer_disable_select_in,
    input  wire logic        xfer_count_zero_in,
    // Interrupt requests.
    output logic             compare_capture_irq_a_out,
    output logic             compare_capture_irq_b_out,
    output logic             irq_out
);
    logic [15:0] channel_counter;
    logic [7:0]  ctrl;
    logic [3:0]  irq_stat;
    logic [3:0]  irq_mask;
    logic        direction_flag;
    logic        match_capture_flag_a;
    logic        match_capture_flag_b;
    logic        overflow_flag;
    logic        underflow_flag;
    logic [15:0] general_reg_a;
    logic [15:0] general_reg_b;
    logic        event_a;
    logic        event_b;
    logic        ovf_evt;
    logic        unf_evt;
    logic        step_now;
    tcs_step_t   step;
    logic        sel_flags;
    logic        sel_gra;
    logic        sel_grb;
    logic        sel_ctrl;
    logic        sel_stat;
    logic        sel_mask;
    logic        flags_rd;
    logic        flags_wr;
    logic        xclr_ok;
    logic [7:0]  flags_view;
    logic [3:0]  evt_vec;
    logic [15:0] next_rdata;

    // Offsets outside the map select nothing, so writes there are lost and reads return zero.
    // Address decode.
    always_comb begin
        sel_flags = 1'b0;
        sel_gra   = 1'b0;
        sel_grb   = 1'b0;
        sel_ctrl  = 1'b0;
        sel_stat  = 1'b0;
        sel_mask  = 1'b0;
        if (addr_in == `TCS_OFF_FLAGS) begin
            sel_flags = 1'b1;
        end else if (addr_in == `TCS_OFF_GRA) begin
            sel_gra = 1'b1;
        end else if (addr_in == `TCS_OFF_GRB) begin
            sel_grb = 1'b1;
        end else if (addr_in == `TCS_OFF_CTRL) begin
            sel_ctrl = 1'b1;
        end else if (addr_in == `TCS_OFF_IRQ_STAT) begin
            sel_stat = 1'b1;
        end else if (addr_in == `TCS_OFF_IRQ_MASK) begin
            sel_mask = 1'b1;
        end
    end

    assign flags_rd = rd_in && sel_flags;
    assign flags_wr = wr_in && sel_flags;
    assign xclr_ok  = !transfer_disable_select_in && !xfer_count_zero_in;

    // Step choice: down only when the up/down mode is enabled.
    // Outside that mode a stray level on the direction input cannot make the counter run backwards.
    always_comb begin
        step = TCS_CNT_HOLD;
        if (ctrl[`TCS_CTRL_RUN] && count_tick_in) begin
            if (ctrl[`TCS_CTRL_UPDN] && count_down_in) begin
                step = TCS_CNT_DOWN;
            end else begin
                step = TCS_CNT_UP;
            end
        end
    end

    assign step_now = (step != TCS_CNT_HOLD);
    assign ovf_evt  = (step == TCS_CNT_UP) && (channel_counter == `TCS_CNT_MAX);
    assign unf_evt  = (step == TCS_CNT_DOWN) && (channel_counter == `TCS_CNT_ZERO);

    // Channel counter.
    // Compare and wrap checks use the value before the step, so a match is seen on the step leaving it.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            channel_counter <= `TCS_CNT_ZERO;
        end else if (step == TCS_CNT_UP) begin
            channel_counter <= channel_counter + 16'h0001;
        end else if (step == TCS_CNT_DOWN) begin
            channel_counter <= channel_counter - 16'h0001;
        end
    end

    // Direction flag tracks the last step taken.
    // It shows up counting after reset and whenever the up/down mode is off.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            direction_flag <= 1'b1;
        end else if (!ctrl[`TCS_CTRL_UPDN]) begin
            direction_flag <= 1'b1;
        end else if (step_now) begin
            direction_flag <= (step == TCS_CNT_UP);
        end
    end

    // Control register: run, up/down mode, capture modes and enables.
    // The overflow and underflow enables are only stored; no request in this block uses them.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ctrl <= 8'h00;
        end else if (wr_in && sel_ctrl) begin
            ctrl <= wdata_in[7:0];
        end
    end

    // General registers A and B.
    // Both see the counter before the step, so a capture and a match agree on the value.
    tcs_gr u_gr_a (
        .clk_in        (clk_in),
        .rst_n_in      (rst_n_in),
        .cap_mode_in   (ctrl[`TCS_CTRL_CAP_A]),
        .capture_in    (capture_a_in),
        .wr_in         (wr_in && sel_gra),
        .wdata_in      (wdata_in),
        .count_in      (channel_counter),
        .count_step_in (step_now),
        .value_out     (general_reg_a),
        .event_out     (event_a)
    );

    tcs_gr u_gr_b (
        .clk_in        (clk_in),
        .rst_n_in      (rst_n_in),
        .cap_mode_in   (ctrl[`TCS_CTRL_CAP_B]),
        .capture_in    (capture_b_in),
        .wr_in         (wr_in && sel_grb),
        .wdata_in      (wdata_in),
        .count_in      (channel_counter),
        .count_step_in (step_now),
        .value_out     (general_reg_b),
        .event_out     (event_b)
    );

    // Event flags; transfer clears only for the compare/capture flags.
    // A transfer clear needs no earlier read; only its own qualifiers gate it.
    // The overflow and underflow flags have no transfer clear, so that input is tied low.
    tcs_flag u_flag_a (
        .clk_in        (clk_in),
        .rst_n_in      (rst_n_in),
        .set_in        (event_a),
        .read_in       (flags_rd),
        .write_zero_in (flags_wr && !wdata_in[`TCS_BIT_FLAG_A]),
        .xfer_clear_in (xfer_act_a_in && xclr_ok),
        .flag_out      (match_capture_flag_a)
    );

    tcs_flag u_flag_b (
        .clk_in        (clk_in),
        .rst_n_in      (rst_n_in),
        .set_in        (event_b),
        .read_in       (flags_rd),
        .write_zero_in (flags_wr && !wdata_in[`TCS_BIT_FLAG_B]),
        .xfer_clear_in (xfer_act_b_in && xclr_ok),
        .flag_out      (match_capture_flag_b)
    );

    tcs_flag u_flag_v (
        .clk_in        (clk_in),
        .rst_n_in      (rst_n_in),
        .set_in        (ovf_evt),
        .read_in       (flags_rd),
        .write_zero_in (flags_wr && !wdata_in[`TCS_BIT_OVF]),
        .xfer_clear_in (1'b0),
        .flag_out      (overflow_flag)
    );

    tcs_flag u_flag_u (
        .clk_in        (clk_in),
        .rst_n_in      (rst_n_in),
        .set_in        (unf_evt),
        .read_in       (flags_rd),
        .write_zero_in (flags_wr && !wdata_in[`TCS_BIT_UNF]),
        .xfer_clear_in (1'b0),
        .flag_out      (underflow_flag)
    );

    // Status view with fixed reserved bits.
    // Reserved bits come from a constant, so no write path can reach them.
    always_comb begin
        flags_view                 = `TCS_FLAGS_RESERVED;
        flags_view[`TCS_BIT_FLAG_A] = match_capture_flag_a;
        flags_view[`TCS_BIT_FLAG_B] = match_capture_flag_b;
        flags_view[`TCS_BIT_OVF]    = overflow_flag;
        flags_view[`TCS_BIT_UNF]    = underflow_flag;
        flags_view[`TCS_BIT_DIR]    = direction_flag;
    end

    // Sticky interrupt status: events set, write one clears, set wins.
    // Write-one-to-clear keeps this status apart from the read-then-write-zero flag protocol.
    assign evt_vec = {unf_evt, ovf_evt, event_b, event_a};
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            irq_stat <= 4'h0;
        end else if (wr_in && sel_stat) begin
            irq_stat <= (irq_stat & ~wdata_in[3:0]) | evt_vec;
        end else begin
            irq_stat <= irq_stat | evt_vec;
        end
    end

    // Interrupt mask.
    // A mask bit gates the shared request line but never the status bit behind it.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            irq_mask <= 4'h0;
        end else if (wr_in && sel_mask) begin
            irq_mask <= wdata_in[3:0];
        end
    end

    // Interrupt outputs, registered.
    // Registering costs one cycle of latency but keeps every output on a flip-flop.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            compare_capture_irq_a_out <= 1'b0;
            compare_capture_irq_b_out <= 1'b0;
            irq_out                   <= 1'b0;
        end else begin
            compare_capture_irq_a_out <= match_capture_flag_a && ctrl[`TCS_CTRL_IEN_A];
            compare_capture_irq_b_out <= match_capture_flag_b && ctrl[`TCS_CTRL_IEN_B];
            irq_out                   <= |(irq_stat & irq_mask);
        end
    end

    // Read mux; unmapped addresses read zero.
    always_comb begin
        next_rdata = 16'h0000;
        if (sel_flags) begin
            next_rdata = {8'h00, flags_view};
        end else if (sel_gra) begin
            next_rdata = general_reg_a;
        end else if (sel_grb) begin
            next_rdata = general_reg_b;
        end else if (sel_ctrl) begin
            next_rdata = {8'h00, ctrl};
        end else if (sel_stat) begin
            next_rdata = {12'h000, irq_stat};
        end else if (sel_mask) begin
            next_rdata = {12'h000, irq_mask};
        end
    end

    // Read data stands only in the cycle after the read strobe.
    // Zero outside the answer cycle keeps stale data off the shared read bus.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rdata_out <= 16'h0000;
        end else if (rd_in) begin
            rdata_out <= next_rdata;
        end else begin
            rdata_out <= 16'h0000;
        end
    end
endmodule

//--- verif/tcs_channel_asserts.sv
// Port checker for the timer channel: read timing, event flags and interrupt gating.
// Assumes it is bound to tcs_channel and sees only that module's ports.
`timescale 1ns/1ps
`include "tcs_consts.svh"
module tcs_channel_asserts (
    // Clock, reset and register port.
    input wire logic        clk_in,
    input wire logic        rst_n_in,
    input wire logic [15:0] addr_in,
    input wire logic [15:0] wdata_in,
    input wire logic        wr_in,
    input wire logic        rd_in,
    input wire logic [15:0] rdata_out,
    // Events and transfer clears.
    input wire logic        count_tick_in,
    input wire logic        count_down_in,
    input wire logic        capture_a_in,
    input wire logic        capture_b_in,
    input wire logic        xfer_act_a_in,
    input wire logic        transfer_disable_select_in,
    input wire logic        xfer_count_zero_in,
    // Interrupts.
    input wire logic        compare_capture_irq_a_out,
    input wire logic        compare_capture_irq_b_out,
    input wire logic        irq_out
);
    logic [7:0]  ctrl;
    logic [3:0]  mask;
    logic [15:0] cnt;
    logic [15:0] gra;
    logic        step_dn;
    logic        ien_a;
    logic        mask_any;
    // Decoded views of the shadow registers.
    assign step_dn  = ctrl[`TCS_CTRL_UPDN] && count_down_in;
    assign ien_a    = ctrl[`TCS_CTRL_IEN_A];
    assign mask_any = |mask;
    // Shadow of control, mask, counter and register A rebuilt from port traffic.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ctrl <= 8'h00;
            mask <= 4'h0;
            cnt  <= 16'h0000;
            gra  <= `TCS_GR_RESET;
        end else begin
            if (wr_in && addr_in == `TCS_OFF_CTRL) ctrl <= wdata_in[7:0];
            if (wr_in && addr_in == `TCS_OFF_IRQ_MASK) mask <= wdata_in[3:0];
            if (capture_a_in && ctrl[`TCS_CTRL_CAP_A]) gra <= cnt;
            else if (wr_in && addr_in == `TCS_OFF_GRA) gra <= wdata_in;
            if (count_tick_in && ctrl[`TCS_CTRL_RUN]) cnt <= step_dn ? cnt - 16'h0001 : cnt + 16'h0001;
        end
    end
    default clocking @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);
    a_rdata_idle: assert property (!$past(rd_in) |-> rdata_out == 16'h0000)
        else $error("read data outside answer cycle");
    a_flags_fixed: assert property (rd_in && addr_in == `TCS_OFF_FLAGS
        |=> rdata_out[15:8] == 8'h00 && rdata_out[6] && rdata_out[3:2] == 2'b00)
        else $error("status reserved bits wrong");
    a_match_irq_a: assert property (count_tick_in && ctrl[`TCS_CTRL_RUN] && !ctrl[`TCS_CTRL_CAP_A]
        && ien_a && !wr_in && cnt == gra |-> ##2 compare_capture_irq_a_out)
        else $error("compare match A missed");
    a_capture_irq_a: assert property (capture_a_in && ctrl[`TCS_CTRL_CAP_A] && ien_a && !wr_in
        |-> ##2 compare_capture_irq_a_out)
        else $error("capture A missed");
    a_capture_irq_b: assert property (capture_b_in && ctrl[`TCS_CTRL_CAP_B] && ctrl[`TCS_CTRL_IEN_B]
        && !wr_in |-> ##2 compare_capture_irq_b_out)
        else $error("capture B missed");
    a_irq_gate_a: assert property (!$past(ien_a) |-> !compare_capture_irq_a_out)
        else $error("request A while disabled");
    a_xfer_clear_a: assert property (xfer_act_a_in && !transfer_disable_select_in
        && !xfer_count_zero_in && !count_tick_in && !capture_a_in |-> ##2 !compare_capture_irq_a_out)
        else $error("transfer clear A ignored");
    a_irq_mask: assert property (!$past(mask_any) |-> !irq_out)
        else $error("interrupt while all masked");
endmodule

//--- verif/tcs_xfer_model.sv
// Behavioural transfer controller: one activation per rising request A or B.
// Assumes the request is the channel's level interrupt output on clk_in.
`timescale 1ns/1ps
module tcs_xfer_model (
    // Clock and reset.
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    // Bench settings and channel request.
    input  wire logic enable_in,
    input  wire logic disable_sel_in,
    input  wire logic count_zero_in,
    input  wire logic irq_a_in,
    input  wire logic irq_b_in,
    // Activation and its qualifiers.
    output logic      act_a_out,
    output logic      act_b_out,
    output logic      disable_sel_out,
    output logic      count_zero_out
);
    logic irq_a_q;
    logic irq_b_q;
    // Pulse on a new request; qualifiers are registered levels.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            irq_a_q         <= 1'b0;
            irq_b_q         <= 1'b0;
            act_a_out       <= 1'b0;
            act_b_out       <= 1'b0;
            disable_sel_out <= 1'b0;
            count_zero_out  <= 1'b0;
        end else begin
            irq_a_q         <= irq_a_in;
            irq_b_q         <= irq_b_in;
            act_b_out       <= enable_in && irq_b_in && !irq_b_q;
            act_a_out       <= enable_in && irq_a_in && !irq_a_q;
            disable_sel_out <= disable_sel_in;
            count_zero_out  <= count_zero_in;
        end
    end
endmodule

//--- verif/test_tcs_channel.sv
// Self-checking bench for the timer channel over its register port.
// Assumes the channel, its checker and the transfer controller model are compiled before it.
`timescale 1ns/1ps
`include "tcs_consts.svh"
module test_tcs_channel import tcs_pkg::*;;
    logic        clk_in = 1'b0;
    logic        rst_n_in = 1'b0;
    logic [15:0] addr_in = 16'h0000;
    logic [15:0] wdata_in = 16'h0000;
    logic        wr_in = 1'b0;
    logic        rd_in = 1'b0;
    logic        tick_in = 1'b0;
    logic        down_in = 1'b0;
    logic        cap_a = 1'b0;
    logic        cap_b = 1'b0;
    logic        xfer_on = 1'b0;
    logic        dis_sel = 1'b0;
    logic        cnt_zero = 1'b0;
    logic [15:0] rdata_out;
    logic        act_a;
    logic        act_b;
    logic        dis_q;
    logic        zero_q;
    logic        irq_a;
    logic        irq_b;
    logic        irq_out;
    int          mismatches = 0;
    int          checks = 0;
    // Free-running 250 MHz clock.
    always #2 clk_in = ~clk_in;
    tcs_channel i_tcs_channel (.clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
        .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .count_tick_in(tick_in), .count_down_in(down_in),
        .capture_a_in(cap_a), .capture_b_in(cap_b), .xfer_act_a_in(act_a), .xfer_act_b_in(act_b),
        .transfer_disable_select_in(dis_q), .xfer_count_zero_in(zero_q), .compare_capture_irq_a_out(irq_a),
        .compare_capture_irq_b_out(irq_b), .irq_out(irq_out));
    tcs_xfer_model i_tcs_xfer_model (.clk_in(clk_in), .rst_n_in(rst_n_in), .enable_in(xfer_on),
        .disable_sel_in(dis_sel), .count_zero_in(cnt_zero), .irq_a_in(irq_a), .irq_b_in(irq_b), .act_a_out(act_a),
        .act_b_out(act_b), .disable_sel_out(dis_q), .count_zero_out(zero_q));
    // Comparison with a one-line report on mismatch.
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Verdict and end of run.
    task automatic summarize;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // One-cycle write and read strobes; read data are checked in the answer cycle.
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk_in);
        addr_in  <= a;
        wdata_in <= d;
        wr_in    <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [15:0] exp);
        @(posedge clk_in);
        addr_in <= a;
        rd_in   <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1;
        chk(rdata_out, exp);
    endtask
    // Counter steps and capture pulses, one cycle each.
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge clk_in);
            tick_in <= 1'b1;
            @(posedge clk_in);
            tick_in <= 1'b0;
        end
    endtask
    task automatic capture(input logic b);
        @(posedge clk_in);
        cap_a <= !b;
        cap_b <= b;
        @(posedge clk_in);
        cap_a <= 1'b0;
        cap_b <= 1'b0;
    endtask
    task automatic settle;
        repeat (2) @(posedge clk_in);
        #1;
    endtask
    task automatic wait_irq_a;
        int i;
        for (i = 0; i < 20 && irq_a !== 1'b1; i++) @(posedge clk_in);
        if (irq_a !== 1'b1) begin
            chk({15'h0000, irq_a}, 16'h0001);
            summarize();
        end
    endtask
    // Main sequence: reset values, compare, clearing, interrupts, capture, transfers, wrap.
    initial begin
        repeat (12) @(posedge clk_in);
        rst_n_in <= 1'b1;
        rd(`TCS_OFF_FLAGS, 16'h00C0);
        rd(`TCS_OFF_GRA, `TCS_GR_RESET);
        rd(`TCS_OFF_GRB, `TCS_GR_RESET);
        rd(16'h0100, 16'h0000);
        wr(`TCS_OFF_FLAGS, 16'h00FF);
        rd(`TCS_OFF_FLAGS, 16'h00C0);
        wr(`TCS_OFF_GRA, 16'h0003);
        wr(`TCS_OFF_GRB, 16'h0005);
        wr(`TCS_OFF_IRQ_MASK, 16'h0003);
        down_in <= 1'b1;
        wr(`TCS_OFF_CTRL, 16'h0031);
        tick(4);
        wr(`TCS_OFF_FLAGS, 16'h0000);
        rd(`TCS_OFF_FLAGS, 16'h00C1);
        tick(2);
        rd(`TCS_OFF_FLAGS, 16'h00C3);
        settle();
        chk({13'h0000, irq_a, irq_b, irq_out}, 16'h0007);
        wr(`TCS_OFF_FLAGS, 16'h00FF);
        rd(`TCS_OFF_FLAGS, 16'h00C3);
        wr(`TCS_OFF_FLAGS, 16'h0000);
        rd(`TCS_OFF_FLAGS, 16'h00C0);
        wr(`TCS_OFF_IRQ_MASK, 16'h0000);
        settle();
        chk({13'h0000, irq_a, irq_b, irq_out}, 16'h0000);
        wr(`TCS_OFF_IRQ_MASK, 16'h0003);
        settle();
        chk({15'h0000, irq_out}, 16'h0001);
        wr(`TCS_OFF_IRQ_STAT, 16'h0003);
        settle();
        chk({15'h0000, irq_out}, 16'h0000);
        wr(`TCS_OFF_CTRL, 16'h003D);
        xfer_on <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            dis_sel  <= (i == 0);
            cnt_zero <= (i == 1);
            capture(1'b0);
            capture(1'b1);
            wait_irq_a();
            settle();
            rd(`TCS_OFF_FLAGS, (i == 2) ? 16'h00C0 : 16'h00C3);
            wr(`TCS_OFF_FLAGS, 16'h0000);
            settle();
        end
        rd(`TCS_OFF_GRA, 16'h0006);
        xfer_on <= 1'b0;
        capture(1'b0);
        rd(`TCS_OFF_FLAGS, 16'h00C1);
        fork
            wr(`TCS_OFF_FLAGS, 16'h0000);
            capture(1'b0);
        join
        rd(`TCS_OFF_FLAGS, 16'h00C1);
        wr(`TCS_OFF_CTRL, 16'h0029);
        capture(1'b1);
        rd(`TCS_OFF_FLAGS, 16'h00C3);
        rd(`TCS_OFF_GRB, 16'h0006);
        wr(`TCS_OFF_CTRL, 16'h0003);
        tick(7);
        rd(`TCS_OFF_FLAGS, 16'h0063);
        down_in <= 1'b0;
        tick(1);
        rd(`TCS_OFF_FLAGS, 16'h00F3);
        rd(`TCS_OFF_IRQ_STAT, 16'h000F);
        summarize();
    end
endmodule
bind tcs_channel tcs_channel_asserts i_tcs_channel_asserts (.clk_in, .rst_n_in, .addr_in, .wdata_in, .wr_in,
    .rd_in, .rdata_out, .count_tick_in, .count_down_in, .capture_a_in, .capture_b_in, .xfer_act_a_in,
    .transfer_disable_select_in, .xfer_count_zero_in, .compare_capture_irq_a_out, .compare_capture_irq_b_out,
    .irq_out);
